// *** rtl/awc_pkg.sv ***
// Package for the converter window comparator: register map, fields, timing.
package awc_pkg;
  localparam logic [7:0] AWC_ADDR_LT_LOW = 8'hC5;
  localparam logic [7:0] AWC_ADDR_LT_HIGH = 8'hC4;
  localparam logic [7:0] AWC_ADDR_GT_LOW = 8'hC3;
  localparam logic [7:0] AWC_ADDR_GT_HIGH = 8'hC6;
  localparam logic [7:0] AWC_ADDR_CTRL = 8'hE8;
  localparam logic [7:0] AWC_ADDR_CONFIG = 8'hBC;
  localparam logic [7:0] AWC_ADDR_RES_LOW = 8'hBD;
  localparam logic [7:0] AWC_ADDR_RES_HIGH = 8'hBE;
  localparam logic [7:0] AWC_ADDR_IRQ_STATUS = 8'hD0;
  localparam logic [7:0] AWC_ADDR_IRQ_MASK = 8'hD4;
  localparam logic [7:0] AWC_RESET_BYTE = 8'h00;
  localparam logic [15:0] AWC_RESET_WORD = 16'h0000;
  localparam int AWC_CTRL_WINT_BIT = 3;
  localparam int AWC_CTRL_CINT_BIT = 5;
  localparam int AWC_CFG_LJST_BIT = 2;
  localparam int AWC_CFG_DIFF_BIT = 0;
  localparam int AWC_IRQ_WIN_BIT = 0;
  localparam int AWC_IRQ_DONE_BIT = 1;
  localparam logic [1:0] AWC_IRQ_RESET = 2'h0;
  localparam int AWC_SAR_CLOCKS = 10;
  localparam logic [4:0] AWC_SAR_DIV_RESET = 5'h1F;
  localparam int AWC_LJST_SHIFT = 6;
  typedef struct packed {
    logic [15:0] data;
    logic valid;
  } awc_result_type;
endpackage

// *** rtl/awc_window_comparator.sv ***
// Converter window comparator with classic Wishbone register slave.
// Functional notes
// - Less-than low byte at C5, reset zero
// - Single-ended results compare as unsigned
// - Inside window: strictly between both limits
// - Outside window: strictly beyond either bound
// - Differential results compare as signed
// - Differential inside uses signed limits
// - Differential outside uses signed bounds
// - Left-justified compare matches right-justified outcome
// - Conversion takes at least ten SAR clocks
// - Match sets control bit 3 until cleared
// - Right-justified high byte sign-extends bit 9
// - Mode chosen by limit contents, compared signed when the differential bit is set
module awc_window_comparator
  import awc_pkg::*;
(
  input wire logic CORE_CLK, // System clock, 10 MHz
  input wire logic RESET, // Synchronous reset, active high
  input wire logic [7:0] WB_ADR_I, // Register address
  input wire logic [7:0] WB_DAT_I, // Write data
  output logic [7:0] WB_DAT_O, // Read data
  input wire logic WB_WE_I, // Write enable
  input wire logic WB_SEL_I, // Byte select
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  output logic WB_ACK_O, // Acknowledge
  input wire logic [9:0] SAR_CODE, // Raw code from the analog core
  input wire logic SAR_START, // Start conversion pulse
  output logic SAR_BUSY, // Conversion in progress
  output logic IRQ // Level interrupt
);
  logic [7:0] lt_low, lt_high, gt_low, gt_high;
  logic [7:0] cfg;
  logic wint, cint;
  logic [1:0] irq_status, irq_mask;
  awc_result_type result;
  logic [4:0] div_cnt;
  logic sar_tick;
  logic [3:0] bit_cnt;
  logic conv_done;
  logic [15:0] next_word;
  logic bus_req, bus_wr, wr_ctrl, wr_irq;
  logic window_hit;

  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign bus_wr = bus_req && WB_WE_I && WB_SEL_I;
  assign wr_ctrl = bus_wr && (WB_ADR_I == AWC_ADDR_CTRL);
  assign wr_irq = bus_wr && (WB_ADR_I == AWC_ADDR_IRQ_STATUS);

  // One-cycle acknowledge; the ack drops in the following cycle
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // Limit and configuration registers
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      lt_low <= AWC_RESET_BYTE;
      lt_high <= AWC_RESET_BYTE;
      gt_low <= AWC_RESET_BYTE;
      gt_high <= AWC_RESET_BYTE;
      cfg <= AWC_RESET_BYTE;
      irq_mask <= AWC_IRQ_RESET;
    end else if (bus_wr) begin
      if (WB_ADR_I == AWC_ADDR_LT_LOW) begin
        lt_low <= WB_DAT_I;
      end else if (WB_ADR_I == AWC_ADDR_LT_HIGH) begin
        lt_high <= WB_DAT_I;
      end else if (WB_ADR_I == AWC_ADDR_GT_LOW) begin
        gt_low <= WB_DAT_I;
      end else if (WB_ADR_I == AWC_ADDR_GT_HIGH) begin
        gt_high <= WB_DAT_I;
      end else if (WB_ADR_I == AWC_ADDR_CONFIG) begin
        cfg <= WB_DAT_I;
      end else if (WB_ADR_I == AWC_ADDR_IRQ_MASK) begin
        irq_mask <= WB_DAT_I[1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WB_DAT_O <= AWC_RESET_BYTE;
    end else if (bus_req) begin
      if (WB_ADR_I == AWC_ADDR_LT_LOW) begin
        WB_DAT_O <= lt_low;
      end else if (WB_ADR_I == AWC_ADDR_LT_HIGH) begin
        WB_DAT_O <= lt_high;
      end else if (WB_ADR_I == AWC_ADDR_GT_LOW) begin
        WB_DAT_O <= gt_low;
      end else if (WB_ADR_I == AWC_ADDR_GT_HIGH) begin
        WB_DAT_O <= gt_high;
      end else if (WB_ADR_I == AWC_ADDR_CONFIG) begin
        WB_DAT_O <= cfg;
      end else if (WB_ADR_I == AWC_ADDR_CTRL) begin
        WB_DAT_O <= {2'h0, cint, SAR_BUSY, wint, 3'h0};
      end else if (WB_ADR_I == AWC_ADDR_RES_LOW) begin
        WB_DAT_O <= result.data[7:0];
      end else if (WB_ADR_I == AWC_ADDR_RES_HIGH) begin
        WB_DAT_O <= result.data[15:8];
      end else if (WB_ADR_I == AWC_ADDR_IRQ_STATUS) begin
        WB_DAT_O <= {6'h00, irq_status};
      end else if (WB_ADR_I == AWC_ADDR_IRQ_MASK) begin
        WB_DAT_O <= {6'h00, irq_mask};
      end else begin
        WB_DAT_O <= AWC_RESET_BYTE;
      end
    end
  end

  // SAR clock enable, divided from the system clock by a fixed 32 (reload value AWC_SAR_DIV_RESET)
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !SAR_BUSY || sar_tick) begin
      div_cnt <= AWC_SAR_DIV_RESET;
    end else begin
      div_cnt <= div_cnt - 5'h01;
    end
  end
  assign sar_tick = SAR_BUSY && (div_cnt == 5'h00);

  // Conversion sequencer: ten SAR clocks per result
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      SAR_BUSY <= 1'b0;
      bit_cnt <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (!SAR_BUSY && SAR_START) begin
        SAR_BUSY <= 1'b1;
        bit_cnt <= 4'h0;
      end else if (sar_tick) begin
        if (bit_cnt == 4'(AWC_SAR_CLOCKS - 1)) begin
          SAR_BUSY <= 1'b0;
          conv_done <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // Justify the raw code into the result word
  always_comb begin
    if (cfg[AWC_CFG_LJST_BIT]) begin
      next_word = {SAR_CODE, 6'h00};
    end else begin
      next_word = {{6{SAR_CODE[9]}}, SAR_CODE};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      result <= '0;
    end else begin
      result.valid <= conv_done;
      if (conv_done) begin
        result.data <= next_word;
      end
    end
  end

  // Window decision; limits are taken in the format software configured.
  // Comparing whole 16-bit words keeps left and right justification equivalent.
  always_comb begin
    logic signed [16:0] res_v, lt_v, gt_v;
    logic diff;
    logic [15:0] cmp_word;
    diff = cfg[AWC_CFG_DIFF_BIT];
    // Sign copies in the high byte would make large unsigned codes look huge
    cmp_word = (diff || cfg[AWC_CFG_LJST_BIT]) ? result.data : 16'(result.data[9:0]);
    res_v = {diff & cmp_word[15], cmp_word};
    lt_v = {diff & lt_high[7], lt_high, lt_low};
    gt_v = {diff & gt_high[7], gt_high, gt_low};
    if (lt_v > gt_v) begin
      window_hit = (res_v > gt_v) && (res_v < lt_v);
    end else begin
      window_hit = (res_v < lt_v) || (res_v > gt_v);
    end
  end

  // Sticky flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wint <= 1'b0;
      cint <= 1'b0;
    end else begin
      if (result.valid && window_hit) begin
        wint <= 1'b1;
      end else if (wr_ctrl && !WB_DAT_I[AWC_CTRL_WINT_BIT]) begin
        wint <= 1'b0;
      end
      if (result.valid) begin
        cint <= 1'b1;
      end else if (wr_ctrl && !WB_DAT_I[AWC_CTRL_CINT_BIT]) begin
        cint <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_status <= AWC_IRQ_RESET;
    end else begin
      irq_status[AWC_IRQ_WIN_BIT] <= (result.valid && window_hit) ||
        (irq_status[AWC_IRQ_WIN_BIT] && !(wr_irq && WB_DAT_I[AWC_IRQ_WIN_BIT]));
      irq_status[AWC_IRQ_DONE_BIT] <= result.valid ||
        (irq_status[AWC_IRQ_DONE_BIT] && !(wr_irq && WB_DAT_I[AWC_IRQ_DONE_BIT]));
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // Checks
  // Limit and result words as software sees them, for the checks below
  logic [15:0] lt_word, gt_word, res10_word;
  assign lt_word = {lt_high, lt_low};
  assign gt_word = {gt_high, gt_low};
  assign res10_word = 16'(result.data[9:0]);

  int unsigned busy_len;
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !SAR_BUSY) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  lt_low_reset_a: assert property (@(posedge CORE_CLK) RESET |=> (lt_low == AWC_RESET_BYTE))
    else $error("less-than low byte not zero after reset");
  unsigned_cmp_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && !cfg[AWC_CFG_DIFF_BIT] && !cfg[AWC_CFG_LJST_BIT] && (lt_word <= gt_word) &&
    (res10_word > gt_word)) |=> wint)
    else $error("unsigned result above limit did not flag");
  inside_hit_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && !cfg[AWC_CFG_DIFF_BIT] && !cfg[AWC_CFG_LJST_BIT] && (lt_word > gt_word) &&
    (res10_word > gt_word) && (res10_word < lt_word)) |=> wint)
    else $error("result inside the window did not flag");
  bound_equal_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && !cfg[AWC_CFG_DIFF_BIT] && !cfg[AWC_CFG_LJST_BIT] &&
    ((res10_word == lt_word) || (res10_word == gt_word))) |-> !window_hit)
    else $error("result equal to a limit matched");
  inside_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && !window_hit && !wint && !wr_ctrl) |=> !wint)
    else $error("flag set without a window hit");
  outside_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && window_hit) |=> wint)
    else $error("window hit did not set flag");
  signed_ext_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && !cfg[AWC_CFG_LJST_BIT]) |-> result.data[15:10] == {6{result.data[9]}})
    else $error("right-justified result not sign extended");
  ljst_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && cfg[AWC_CFG_LJST_BIT]) |-> result.data[5:0] == 6'h00)
    else $error("left-justified low bits not zero");
  conv_len_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(conv_done) |-> busy_len >= 32'(AWC_SAR_CLOCKS) * (32'(AWC_SAR_DIV_RESET) + 32'h1))
    else $error("conversion shorter than ten SAR clocks");
  sticky_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (wint && !wr_ctrl) |=> wint)
    else $error("window flag dropped without a clear");
  irq_level_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    |(irq_status & irq_mask) |=> IRQ)
    else $error("interrupt not raised for unmasked status");
  irq_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !(|(irq_status & irq_mask)) |=> !IRQ)
    else $error("interrupt raised with no unmasked status");
  diff_inside_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && cfg[AWC_CFG_DIFF_BIT] && ($signed(lt_word) > $signed(gt_word)) &&
    ($signed(result.data) > $signed(gt_word)) && ($signed(result.data) < $signed(lt_word)))
    |=> wint)
    else $error("signed result inside the window did not flag");
  diff_outside_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (result.valid && cfg[AWC_CFG_DIFF_BIT] && ($signed(lt_word) <= $signed(gt_word)) &&
    ($signed(result.data) < $signed(lt_word))) |=> wint)
    else $error("signed result below the window did not flag");
  ack_pulse_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held for more than one cycle");
  start_taken_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!SAR_BUSY && SAR_START) |=> SAR_BUSY)
    else $error("start pulse did not begin a conversion");
  inside_cover_c: cover property (@(posedge CORE_CLK) result.valid && window_hit &&
    ({lt_high, lt_low} > {gt_high, gt_low}));
  outside_cover_c: cover property (@(posedge CORE_CLK) result.valid && window_hit &&
    ({lt_high, lt_low} <= {gt_high, gt_low}));
  diff_cover_c: cover property (@(posedge CORE_CLK) result.valid && cfg[AWC_CFG_DIFF_BIT] &&
    window_hit);
  ljst_cover_c: cover property (@(posedge CORE_CLK) result.valid && cfg[AWC_CFG_LJST_BIT] &&
    window_hit);
  clear_cover_c: cover property (@(posedge CORE_CLK) wint ##1 !wint);
endmodule

// *** verif/awc_analog_model.sv ***
// Behavioural stand-in for the analog core that hands raw codes to the comparator.
module awc_analog_model (
  input wire logic clk, // System clock
  input wire logic busy, // Conversion in progress
  input wire logic [9:0] target, // Code for the running conversion
  output logic [9:0] code // Raw code to the comparator
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold = 3'h0;
  always_ff @(posedge clk) begin
    if (busy) begin
      hold <= 3'h5;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // Outside the sampling window the code is stale, so show its inverse to catch late sampling
  assign code = (busy || hold != 3'h0) ? target : ~target;
endmodule

// *** verif/awc_window_comparator_bench.sv ***
// Self-checking bench: register access, window cases, sticky flag and interrupt.
module awc_window_comparator_bench
  import awc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, start = 1'b0;
  logic [7:0] adr = 8'h00, wdat = 8'h00, rdat, r;
  logic ack, busy, irq;
  logic [9:0] code, target = 10'h000;
  int n_fail = 0, checks = 0;
  always #50 clk = ~clk;
  awc_window_comparator dut (.CORE_CLK(clk), .RESET(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_ACK_O(ack), .SAR_CODE(code), .SAR_START(start), .SAR_BUSY(busy), .IRQ(irq));
  awc_analog_model core (.clk(clk), .busy(busy), .target(target), .code(code));
  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; read data is taken at the edge that sees ack
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i == 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task conv(input logic [9:0] c);
    int i, n;
    n = 0;
    target <= c;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
    chk(8'(n >= AWC_SAR_CLOCKS * 32), 8'h01);
    if (i == 1000) begin
      n_fail++;
      report_and_stop();
    end
    repeat (4) @(posedge clk);
  endtask
  // Limits are always written in the configured format
  task tcase(input logic [7:0] cfg, input logic [15:0] lt, gt, input logic [9:0] c,
    input logic e);
    bus(1'b1, AWC_ADDR_CONFIG, cfg);
    bus(1'b1, AWC_ADDR_LT_HIGH, lt[15:8]);
    bus(1'b1, AWC_ADDR_LT_LOW, lt[7:0]);
    bus(1'b1, AWC_ADDR_GT_HIGH, gt[15:8]);
    bus(1'b1, AWC_ADDR_GT_LOW, gt[7:0]);
    bus(1'b1, AWC_ADDR_CTRL, 8'h00);
    conv(c);
    bus(1'b0, AWC_ADDR_CTRL, 8'h00);
    chk(8'(r[AWC_CTRL_WINT_BIT]), 8'(e));
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, AWC_ADDR_LT_LOW, 8'h00);
    chk(r, AWC_RESET_BYTE);
    bus(1'b1, AWC_ADDR_LT_LOW, 8'hA5);
    bus(1'b0, AWC_ADDR_LT_LOW, 8'h00);
    chk(r, 8'hA5);
    bus(1'b0, 8'h00, 8'h00);
    chk(r, 8'h00);
    tcase(8'h00, 16'h0080, 16'h0040, 10'h040, 1'b0);
    tcase(8'h00, 16'h0080, 16'h0040, 10'h080, 1'b0);
    tcase(8'h00, 16'h0080, 16'h0040, 10'h3FF, 1'b0);
    tcase(8'h00, 16'h0040, 16'h0300, 10'h250, 1'b0);
    tcase(8'h00, 16'h0040, 16'h0300, 10'h301, 1'b1);
    tcase(8'h00, 16'h0080, 16'h0040, 10'h041, 1'b1);
    conv(10'h040);
    bus(1'b0, AWC_ADDR_CTRL, 8'h00);
    chk(8'(r[AWC_CTRL_WINT_BIT]), 8'h01);
    tcase(8'h00, 16'h0040, 16'h0080, 10'h03F, 1'b1);
    tcase(8'h00, 16'h0040, 16'h0080, 10'h040, 1'b0);
    tcase(8'h00, 16'h0040, 16'h0080, 10'h080, 1'b0);
    tcase(8'h00, 16'h0040, 16'h0080, 10'h081, 1'b1);
    tcase(8'h01, 16'h0040, 16'hFFFF, 10'h000, 1'b1);
    tcase(8'h01, 16'h0040, 16'hFFFF, 10'h3FF, 1'b0);
    tcase(8'h01, 16'h0040, 16'hFFFF, 10'h040, 1'b0);
    tcase(8'h01, 16'hFFFF, 16'h0040, 10'h3FE, 1'b1);
    tcase(8'h01, 16'hFFFF, 16'h0040, 10'h3FF, 1'b0);
    tcase(8'h01, 16'hFFFF, 16'h0040, 10'h041, 1'b1);
    tcase(8'h04, 16'h2000, 16'h1000, 10'h041, 1'b1);
    tcase(8'h04, 16'h2000, 16'h1000, 10'h040, 1'b0);
    tcase(8'h05, 16'h1000, 16'hFFC0, 10'h3FF, 1'b0);
    tcase(8'h01, 16'hFFFF, 16'h0040, 10'h200, 1'b1);
    bus(1'b0, AWC_ADDR_RES_HIGH, 8'h00);
    chk(r, 8'hFE);
    bus(1'b0, AWC_ADDR_IRQ_STATUS, 8'h00);
    chk(r, 8'h03);
    chk(8'(irq), 8'h00);
    bus(1'b1, AWC_ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk(8'(irq), 8'h01);
    bus(1'b1, AWC_ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk(8'(irq), 8'h00);
    bus(1'b0, AWC_ADDR_IRQ_STATUS, 8'h00);
    chk(r, 8'h02);
    // Reset in mid-run must bring the registers back to zero
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, AWC_ADDR_LT_LOW, 8'h00);
    chk(r, AWC_RESET_BYTE);
    bus(1'b0, AWC_ADDR_IRQ_STATUS, 8'h00);
    chk(r, 8'h00);
    report_and_stop();
  end
endmodule
